// ===== hdl/flash_front_pkg.sv
// package: opcodes, constants and types of the serial flash front end
// ==================================================================
package flash_front_pkg;
  // ================================================================
  // timing and reset values, lane enable codes, fill byte and FIFO size
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          PUW_TIME_NS   = 1000;
  localparam int          PUW_CYCLES    = (PUW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] PUW_INIT      = 16'(PUW_CYCLES);
  localparam logic [3:0]  OE_OFF        = 4'hF;
  localparam logic [3:0]  OE_ONE        = 4'hD;
  localparam logic [3:0]  OE_TWO        = 4'hC;
  localparam logic [3:0]  OE_FOUR       = 4'h0;
  localparam logic [7:0]  FILL_BYTE     = 8'hFF;
  localparam int          FIFO_WIDTH    = 8;
  localparam int          FIFO_DEPTH    = 16;
  // status byte field positions
  localparam int BUSY_BIT = 0, LATCH_BIT = 1, LOCKH_BIT = 0, QUAD_BIT = 1;
  // ================================================================
  // opcodes
  localparam logic [7:0] OP_WREN = 8'h06, OP_WRDI = 8'h04, OP_RDSR1 = 8'h05, OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_WRSR = 8'h01, OP_PP = 8'h02, OP_QPP = 8'h32, OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52, OP_BE64 = 8'hD8, OP_CE1 = 8'hC7, OP_CE2 = 8'h60;
  localparam logic [7:0] OP_ESR = 8'h44, OP_PSR = 8'h42, OP_SUSPEND = 8'h75, OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_PDOWN = 8'hB9, OP_RELEASE = 8'hAB, OP_READ = 8'h03, OP_FAST = 8'h0B;
  localparam logic [7:0] OP_DOUT2 = 8'h3B, OP_DIO2 = 8'hBB, OP_DOUT4 = 8'h6B, OP_DIO4 = 8'hEB;
  localparam logic [7:0] OP_WIO4 = 8'hE7, OP_OIO4 = 8'hE3;
  // ================================================================
  // types
  typedef enum logic [1:0] {W_ONE, W_TWO, W_FOUR} lane_w_t;
  typedef enum logic [2:0] {PH_IDLE, PH_OPC, PH_ADDR, PH_PAD, PH_DIN, PH_DOUT, PH_DONE, PH_IGN} phase_t;
  typedef struct packed {
    logic known; logic addr; lane_w_t aw; logic [3:0] pad; logic din; logic dout;
    lane_w_t dw; logic stat; logic wc; logic latch_req; logic quad;
  } op_info_t;
  typedef struct packed { logic valid; logic [7:0] opcode; logic [23:0] addr; } cmd_t;
  typedef struct packed { logic valid; logic [7:0] data; } wbyte_t;

  // per-opcode framing and gating class
  function automatic op_info_t decode_op(input logic [7:0] op);
    op_info_t i;
    i = '0;
    i.known = 1'h1;
    case (op)
      OP_WREN: i.wc = 1'h1;
      OP_RDSR1, OP_RDSR2: begin i.dout = 1'h1; i.stat = 1'h1; end
      OP_WRSR: begin i.din = 1'h1; i.latch_req = 1'h1; end
      OP_PP, OP_PSR: begin i.addr = 1'h1; i.din = 1'h1; i.latch_req = 1'h1; end
      OP_QPP: begin i.addr = 1'h1; i.din = 1'h1; i.dw = W_FOUR; i.latch_req = 1'h1; end
      OP_SE, OP_BE32, OP_BE64, OP_ESR: begin i.addr = 1'h1; i.latch_req = 1'h1; end
      OP_CE1, OP_CE2: i.latch_req = 1'h1;
      OP_WRDI, OP_SUSPEND, OP_RESUME, OP_PDOWN, OP_RELEASE: i.known = 1'h1;
      OP_READ: begin i.addr = 1'h1; i.dout = 1'h1; end
      OP_FAST: begin i.addr = 1'h1; i.pad = 4'h8; i.dout = 1'h1; end
      OP_DOUT2: begin i.addr = 1'h1; i.pad = 4'h8; i.dout = 1'h1; i.dw = W_TWO; end
      OP_DIO2: begin i.addr = 1'h1; i.aw = W_TWO; i.pad = 4'h4; i.dout = 1'h1; i.dw = W_TWO; end
      OP_DOUT4: begin i.addr = 1'h1; i.pad = 4'h8; i.dout = 1'h1; i.dw = W_FOUR; end
      OP_DIO4: begin i.addr = 1'h1; i.aw = W_FOUR; i.pad = 4'h6; i.dout = 1'h1; i.dw = W_FOUR; end
      OP_WIO4: begin i.addr = 1'h1; i.aw = W_FOUR; i.pad = 4'h4; i.dout = 1'h1; i.dw = W_FOUR; end
      OP_OIO4: begin i.addr = 1'h1; i.aw = W_FOUR; i.pad = 4'h2; i.dout = 1'h1; i.dw = W_FOUR; end
      default: i.known = 1'h0;
    endcase
    i.wc   = i.wc | i.latch_req;
    i.quad = (i.aw == W_FOUR) || (i.dw == W_FOUR);
    return i;
  endfunction : decode_op
endpackage : flash_front_pkg

// ===== hdl/serial_flash_spi_front_end.sv
// serial flash SPI front end with its read-data FIFO
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// read-data FIFO
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } fifo_st_t;
  fifo_st_t    q;
  fifo_st_t    d;
  logic [AW:0] fill;

  // the extra pointer bit keeps full and empty exact
  assign fill      = q.wr - q.rd;
  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = q.mem[q.rd[AW-1:0]];

  // push, pop and flush
  always_comb begin
    d = q;
    if (in_valid && in_ready) begin
      d.mem[q.wr[AW-1:0]] = in_data;
      d.wr = q.wr + 1'h1;
    end
    if (out_valid && out_ready) d.rd = q.rd + 1'h1;
    if (flush) begin
      d.wr = '0;
      d.rd = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) q <= '0;
    else q <= d;
  end
endmodule : word_fifo

// ==================================================================
// serial front end
module serial_flash_spi_front_end
  import flash_front_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic [3:0] lane_i,
  output logic [3:0]      lane_o,
  output logic [3:0]      lane_oe_n,
  input  wire logic       quad_enable,
  input  wire logic       status_lock_low,
  input  wire logic       status_lock_high,
  input  wire logic       op_done,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output logic            rd_ready,
  output cmd_t            cmd,
  output wbyte_t          wr_byte,
  output logic            write_latch_bit,
  output logic            busy,
  output logic            powered_down
);
  typedef struct packed {
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic        sclk_prev;
    phase_t      phase;
    logic [4:0]  cnt;
    logic [23:0] shin;
    logic [7:0]  opcode;
    logic [23:0] addr;
    op_info_t    info;
    logic [7:0]  shout;
    logic [3:0]  left;
    logic        got;
    logic        paused;
    logic        armed;
    logic        latch;
    logic        busy;
    logic        pd;
    logic [15:0] puw;
    logic [3:0]  lane_o;
    logic [3:0]  drv;
    logic [3:0]  oe_n;
    cmd_t        cmd;
    wbyte_t      wrb;
  } st_t;

  st_t        q;
  st_t        d;
  logic       cs_hi;
  logic       sck;
  logic [3:0] lv;
  logic       rise;
  logic       fall;
  logic       locked;
  logic       ok;
  logic       pop;
  logic [7:0] f_data;
  logic       f_valid;
  logic [7:0] opc;
  logic [7:0] byte_out;
  op_info_t   i;

  // bits taken per clock for a lane width
  function automatic logic [3:0] lane_bits(input lane_w_t w);
    case (w)
      W_TWO:   return 4'h2;
      W_FOUR:  return 4'h4;
      default: return 4'h1;
    endcase
  endfunction : lane_bits

  // last clock index of an address or data byte phase
  function automatic logic [4:0] last_clk(input lane_w_t w, input logic is_addr);
    case (w)
      W_TWO:   return is_addr ? 5'h0B : 5'h03;
      W_FOUR:  return is_addr ? 5'h05 : 5'h01;
      default: return is_addr ? 5'h17 : 5'h07;
    endcase
  endfunction : last_clk

  // lane1 (or lane3) carries the most significant bit of a group
  function automatic logic [23:0] shift_in(input logic [23:0] s, input lane_w_t w, input logic [3:0] l);
    case (w)
      W_TWO:   return {s[21:0], l[1:0]};
      W_FOUR:  return {s[19:0], l};
      default: return {s[22:0], l[0]};
    endcase
  endfunction : shift_in

  // pin views after the two-stage synchroniser
  assign cs_hi  = q.sync2[5];
  assign sck    = q.sync2[4];
  assign lv     = q.sync2[3:0];
  assign rise   = sck && !q.sclk_prev;
  assign fall   = !sck && q.sclk_prev;
  assign opc    = {q.shin[6:0], lv[0]};
  assign i      = decode_op(opc);
  // protect pin has no meaning once lane2 is a data lane
  assign locked = status_lock_high || (status_lock_low && !quad_enable && !lv[2]);

  word_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .flush     (cs_hi),
    .in_data   (rd_data),
    .in_valid  (rd_valid),
    .in_ready  (rd_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (pop)
  );

  // frame sequencer: one pass per system clock
  always_comb begin
    d           = q;
    d.sync1     = {cs_n, sclk, lane_i};
    d.sync2     = q.sync1;
    d.sclk_prev = sck;
    d.cmd.valid = 1'h0;
    d.wrb.valid = 1'h0;
    pop         = 1'h0;
    ok          = 1'h0;
    byte_out    = FILL_BYTE;
    if (q.puw != '0) d.puw = q.puw - 16'h0001;
    // engine completion; a start in the same cycle still wins below
    if (op_done) d.busy = 1'h0;
    // pause tracks the pin only while the clock is low
    if (!sck) d.paused = !lv[3] && !cs_hi && !quad_enable && !q.info.quad;
    if (cs_hi) begin
      d.armed  = 1'h1;
      d.paused = 1'h0;
      d.phase  = PH_IDLE;
      d.drv    = OE_OFF;
      d.info   = '0;
      // only a whole instruction takes effect at deselect
      if (q.phase == PH_DONE || (q.phase == PH_DIN && q.cnt == '0 && q.got)) begin
        case (q.opcode)
          OP_WREN:    d.latch = 1'h1;
          OP_WRDI:    d.latch = 1'h0;
          OP_PDOWN:   d.pd = 1'h1;
          OP_RELEASE: d.pd = 1'h0;
          default: begin
            d.cmd = '{1'h1, q.opcode, q.addr};
            if (q.info.latch_req) begin
              d.latch = 1'h0;
              d.busy = 1'h1;
            end
          end
        endcase
      end
    end else if (q.armed && !q.paused) begin
      if (q.phase == PH_IDLE) begin
        d.phase = PH_OPC;
        d.cnt   = '0;
        d.got   = 1'h0;
        d.left  = '0;
      end else if (rise) begin
        d.cnt = q.cnt + 5'h01;
        case (q.phase)
          PH_OPC: begin
            d.shin = {q.shin[22:0], lv[0]};
            if (q.cnt == 5'h07) begin
              ok = i.known;
              if (q.pd && opc != OP_RELEASE) ok = 1'h0;
              if (q.busy && opc != OP_RDSR1 && opc != OP_RDSR2 && opc != OP_SUSPEND) ok = 1'h0;
              if (i.wc && q.puw != '0) ok = 1'h0;
              if (i.latch_req && !q.latch) ok = 1'h0;
              if (i.quad && !quad_enable) ok = 1'h0;
              if (opc == OP_WRSR && locked) ok = 1'h0;
              d.opcode = opc;
              d.info   = i;
              d.cnt    = '0;
              if (i.quad) d.paused = 1'h0;
              // a refused instruction only waits for deselect
              d.phase = !ok ? PH_IGN : i.addr ? PH_ADDR : i.din ? PH_DIN : i.dout ? PH_DOUT : PH_DONE;
            end
          end
          PH_ADDR: begin
            d.shin = shift_in(q.shin, q.info.aw, lv);
            if (q.cnt == last_clk(q.info.aw, 1'h1)) begin
              d.addr = d.shin;
              d.cnt  = '0;
              // reads start at once so the FIFO fills during the pad
              if (q.info.dout) d.cmd = '{1'h1, q.opcode, d.shin};
              d.phase = (q.info.pad != '0) ? PH_PAD : q.info.din ? PH_DIN : q.info.dout ? PH_DOUT : PH_DONE;
            end
          end
          PH_PAD: begin
            if (q.cnt == {1'h0, q.info.pad} - 5'h01) begin
              d.cnt   = '0;
              d.phase = PH_DOUT;
            end
          end
          PH_DIN: begin
            d.shin = shift_in(q.shin, q.info.dw, lv);
            if (q.cnt == last_clk(q.info.dw, 1'h0)) begin
              d.cnt = '0;
              d.got = 1'h1;
              d.wrb = '{1'h1, d.shin[7:0]};
            end
          end
          PH_DONE: d.phase = PH_IGN;
          default: d.cnt = q.cnt;
        endcase
      end else if (fall && q.phase == PH_DOUT) begin
        if (q.left != '0) begin
          byte_out = q.shout;
        end else if (q.info.stat) begin
          byte_out = '0;
          if (q.opcode == OP_RDSR1) begin
            byte_out[BUSY_BIT] = q.busy;
            byte_out[LATCH_BIT] = q.latch;
          end else begin
            byte_out[LOCKH_BIT] = status_lock_high;
            byte_out[QUAD_BIT]  = quad_enable;
          end
        end else if (f_valid) begin
          byte_out = f_data;
          pop      = 1'h1;
        end
        case (q.info.dw)
          W_TWO: begin
            d.lane_o = {2'h0, byte_out[7:6]};
            d.shout  = {byte_out[5:0], 2'h0};
            d.drv    = OE_TWO;
          end
          W_FOUR: begin
            d.lane_o = byte_out[7:4];
            d.shout  = {byte_out[3:0], 4'h0};
            d.drv    = OE_FOUR;
          end
          default: begin
            d.lane_o = {2'h0, byte_out[7], 1'h0};
            d.shout  = {byte_out[6:0], 1'h0};
            d.drv    = OE_ONE;
          end
        endcase
        d.left = ((q.left == '0) ? 4'h8 : q.left) - lane_bits(q.info.dw);
      end
    end
    d.oe_n = (d.paused || cs_hi) ? OE_OFF : d.drv;
  end

  // supply reset clears the state, floats the lanes and holds off the power-up delay
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q      <= '0;
      q.puw  <= PUW_INIT;
      q.drv  <= OE_OFF;
      q.oe_n <= OE_OFF;
    end else begin
      q <= d;
    end
  end

  assign lane_o          = q.lane_o;
  assign lane_oe_n       = q.oe_n;
  assign cmd             = q.cmd;
  assign wr_byte         = q.wrb;
  assign write_latch_bit = q.latch;
  assign busy            = q.busy;
  assign powered_down    = q.pd;

  // ================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_rise_sample: assert property ((rise && !cs_hi && !q.paused && q.phase == PH_OPC) |=>
    (q.phase != PH_OPC || q.cnt == $past(q.cnt) + 5'h01)) else $error("opcode bit not taken on rise");
  chk_out_on_fall: assert property ($changed(q.lane_o) |-> $past(fall))
    else $error("output changed away from a falling edge");
  chk_cs_float: assert property (cs_hi |=> q.oe_n == OE_OFF) else $error("driving while deselected");
  chk_pause_float: assert property (q.paused |-> q.oe_n == OE_OFF) else $error("driving while paused");
  chk_pause_mode: assert property (q.paused |-> !q.info.quad) else $error("paused in quad instruction");
  chk_latch_rise: assert property ($rose(q.latch) |-> $past(q.opcode) == OP_WREN && $past(q.phase) == PH_DONE)
    else $error("latch set without write enable");
  chk_latch_needed: assert property ((q.cmd.valid && decode_op(q.cmd.opcode).latch_req) |->
    ($past(q.latch) && !q.latch && q.busy)) else $error("write command without latch");
  chk_busy_hold: assert property ((q.busy && !op_done) |=> q.busy) else $error("busy dropped early");
  chk_puw_block: assert property ((q.cmd.valid && decode_op(q.cmd.opcode).wc) |-> $past(q.puw) == '0)
    else $error("write command inside power-up delay");
  chk_pd_only: assert property (q.cmd.valid |-> !$past(q.pd)) else $error("command while powered down");
  chk_busy_only: assert property ((q.cmd.valid && $past(q.busy)) |-> q.cmd.opcode == OP_SUSPEND)
    else $error("command accepted while busy");

  cov_status_read: cover property (q.phase == PH_DOUT && q.info.stat && fall);
  cov_pause: cover property ($rose(q.paused));
  cov_quad_read: cover property (q.phase == PH_DOUT && q.drv == OE_FOUR);
  cov_program: cover property (q.cmd.valid && q.cmd.opcode == OP_PP);
endmodule : serial_flash_spi_front_end
`default_nettype wire

// ===== sim/spi_master_model.sv
// host side model: drives select, serial clock and lanes of the flash front end
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  input  wire logic       clk_sys,
  input  wire logic [3:0] lane_o,
  input  wire logic [3:0] lane_oe_n,
  output logic            cs_n,
  output logic            sclk,
  output logic [3:0]      lane_i
);
  logic [3:0] drv;
  logic [3:0] drv_en;
  logic [3:0] seen_oe;
  logic [3:0] pause_oe;

  // ================================================================
  // wire levels
  // a lane nobody drives shows the inverse of the last device value, never a stale copy
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_i[i] = !lane_oe_n[i] ? lane_o[i] : (drv_en[i] ? drv[i] : ~lane_o[i]);
    end
  end

  initial begin
    cs_n     = 1'b1;
    sclk     = 1'b0;
    drv      = 4'hD;
    drv_en   = 4'hD;
    seen_oe  = 4'hF;
    pause_oe = 4'h0;
  end

  // ================================================================
  // frame driver
  task automatic half();
    repeat (4) @(negedge clk_sys);
  endtask : half

  // n_out bits msb first on lane0, then n_in bits taken from lane1 at each rise
  task automatic frame(input logic m3, input logic wp, input logic [63:0] tx, input int n_out,
                       input int n_in, input int pz, output logic [7:0] rx);
    rx = 8'h00;
    @(negedge clk_sys);
    drv[2] = wp;
    sclk   = m3;
    half();
    cs_n = 1'b0;
    half();
    for (int k = 0; k < n_out + n_in; k++) begin
      sclk   = 1'b0;
      drv[0] = (k < n_out) ? tx[63-k] : 1'b0;
      half();
      if (k == pz) begin
        // select stays low for the whole pause, junk clocks meanwhile
        drv[3] = 1'b0;
        half();
        pause_oe = lane_oe_n;
        repeat (2) begin
          sclk   = 1'b1;
          drv[0] = ~drv[0];
          half();
          sclk = 1'b0;
          half();
        end
        drv[3] = 1'b1;
        drv[0] = (k < n_out) ? tx[63-k] : 1'b0;
        half();
      end
      if (k >= n_out) rx = {rx[6:0], lane_i[1]};
      seen_oe = lane_oe_n;
      sclk    = 1'b1;
      half();
    end
    sclk = m3;
    half();
    cs_n = 1'b1;
    half();
    half();
  endtask : frame
endmodule : spi_master_model
`default_nettype wire

// ===== sim/tb_serial_flash_spi_front_end.sv
// self-checking testbench of the serial flash front end
`timescale 1ns/1ps
`default_nettype none
module tb_serial_flash_spi_front_end import flash_front_pkg::*; ;
  typedef struct {
    logic m3, quad, lkh, lkl, wp, dn;
    logic [63:0] tx;
    int n_out, n_in;
    logic [7:0] rx;
    logic [3:0] oe;
    logic lat, bsy;
    int ncmd;
  } row_t;

  logic       clk_sys = 1'b0;
  logic       rst_n, quad_en, lkl, lkh, op_done, cs_n, sclk, rd_ready, latch, busy, pd;
  logic [3:0] lane_i, lane_o, lane_oe_n;
  logic [7:0] rx;
  cmd_t       cmd, last_cmd;
  wbyte_t     wr_byte, last_wb;
  int         n_fail = 0, comparisons = 0, n_cmd = 0, cyc = 0, base;
  row_t       rows [22];

  always #20 clk_sys = ~clk_sys;

  serial_flash_spi_front_end u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .lane_i(lane_i), .lane_o(lane_o),
    .lane_oe_n(lane_oe_n), .quad_enable(quad_en), .status_lock_low(lkl), .status_lock_high(lkh),
    .op_done(op_done), .rd_data(8'hA5), .rd_valid(1'b1), .rd_ready(rd_ready), .cmd(cmd),
    .wr_byte(wr_byte), .write_latch_bit(latch), .busy(busy), .powered_down(pd)
  );

  spi_master_model u_master (
    .clk_sys(clk_sys), .lane_o(lane_o), .lane_oe_n(lane_oe_n), .cs_n(cs_n), .sclk(sclk), .lane_i(lane_i)
  );

  // ================================================================
  // counting, checking and closing
  always @(posedge clk_sys) begin
    if (cmd.valid === 1'b1) n_cmd <= n_cmd + 1;
    if (cmd.valid === 1'b1) last_cmd <= cmd;
    if (wr_byte.valid === 1'b1) last_wb <= wr_byte;
  end

  // ceiling well above the roughly 4800 cycles the tests need
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // ================================================================
  // main sequence
  initial begin
    rst_n   = 1'b0;
    quad_en = 1'b0;
    lkl     = 1'b0;
    lkh     = 1'b0;
    op_done = 1'b0;
    rows = '{
      '{0,0,0,0,1,0,{8'h02,24'h000100,8'hAA,24'h0},40,0,8'h00,OE_OFF,0,0,0},
      '{0,0,0,0,1,0,{8'h06,56'h0},8,0,8'h00,OE_OFF,1,0,0},
      '{1,0,0,0,1,0,{8'h05,56'h0},8,8,8'h02,OE_ONE,1,0,0},
      '{0,0,0,0,1,0,{8'h04,56'h0},8,0,8'h00,OE_OFF,0,0,0},
      '{1,0,0,0,1,0,{8'h06,56'h0},8,0,8'h00,OE_OFF,1,0,0},
      '{0,0,0,0,1,0,{8'h20,24'h001000,32'h0},32,0,8'h00,OE_OFF,0,1,1},
      '{0,0,0,0,1,0,{8'h06,56'h0},8,0,8'h00,OE_OFF,0,1,0},
      '{1,0,0,0,1,0,{8'h05,56'h0},8,8,8'h01,OE_ONE,0,1,0},
      '{0,0,0,0,1,1,{8'h06,56'h0},8,0,8'h00,OE_OFF,1,0,0},
      '{0,0,1,0,1,0,{8'h01,56'h0},16,0,8'h00,OE_OFF,1,0,0},
      '{0,0,0,1,0,0,{8'h01,56'h0},16,0,8'h00,OE_OFF,1,0,0},
      '{0,0,0,1,1,0,{8'h01,56'h0},16,0,8'h00,OE_OFF,0,1,1},
      '{0,1,0,0,1,1,{8'h35,56'h0},8,8,8'h02,OE_ONE,0,0,0},
      '{0,0,0,0,1,0,{8'h6B,56'h0},40,0,8'h00,OE_OFF,0,0,0},
      '{0,1,0,0,1,0,{8'h6B,56'h0},40,2,8'h02,OE_FOUR,0,0,1},
      '{0,0,0,0,1,0,{8'h3B,56'h0},40,4,8'h0C,OE_TWO,0,0,1},
      '{1,0,0,0,1,0,{8'h03,56'h0},32,8,8'hA5,OE_ONE,0,0,1},
      '{0,0,0,0,1,0,{8'h06,56'h0},8,0,8'h00,OE_OFF,1,0,0},
      '{0,0,0,0,1,0,{8'hB9,56'h0},8,0,8'h00,OE_OFF,1,0,0},
      '{0,0,0,0,1,0,{8'h04,56'h0},8,0,8'h00,OE_OFF,1,0,0},
      '{0,0,0,0,1,0,{8'hAB,56'h0},8,0,8'h00,OE_OFF,1,0,0},
      '{0,0,0,0,1,0,{8'h04,56'h0},8,0,8'h00,OE_OFF,0,0,0}};
    repeat (10) @(negedge clk_sys);
    check(8'({latch, busy, pd}), 8'h00);
    check(8'(lane_oe_n), 8'(OE_OFF));
    rst_n = 1'b1;
    // wait out the power-up write delay and let select be seen high
    repeat (40) @(negedge clk_sys);
    foreach (rows[i]) begin
      quad_en = rows[i].quad;
      lkh = rows[i].lkh;
      lkl = rows[i].lkl;
      if (rows[i].dn) begin
        op_done = 1'b1;
        @(negedge clk_sys);
        op_done = 1'b0;
      end
      base = n_cmd;
      u_master.frame(rows[i].m3, rows[i].wp, rows[i].tx, rows[i].n_out, rows[i].n_in, -1, rx);
      check(rx, rows[i].rx);
      check(8'(u_master.seen_oe), 8'(rows[i].oe));
      check(8'(latch), 8'(rows[i].lat));
      check(8'(busy), 8'(rows[i].bsy));
      check(8'(n_cmd - base), 8'(rows[i].ncmd));
      $display("test %0d done", i);
    end
    // pause inside the opcode and inside read data; junk clocks while paused must not count
    u_master.frame(0, 1, {8'h06, 56'h0}, 8, 0, 3, rx);
    check(8'(latch), 8'h01);
    u_master.frame(0, 1, {8'h05, 56'h0}, 8, 8, 11, rx);
    check(rx, 8'h02);
    check(8'(u_master.pause_oe), 8'(OE_OFF));
    $display("test pause done");
    // select released in mid-address leaves no trace
    base = n_cmd;
    u_master.frame(0, 1, {8'h20, 56'h0}, 28, 0, -1, rx);
    check(8'({latch, busy, 6'(n_cmd - base)}), 8'h80);
    $display("test abort done");
    // a latched program hands its opcode, address and data byte to the engine
    u_master.frame(0, 1, {8'h02, 24'h00C300, 8'h5A, 24'h0}, 40, 0, -1, rx);
    check(last_cmd.opcode, OP_PP);
    check(last_cmd.addr[15:8], 8'hC3);
    check(last_wb.data, 8'h5A);
    check(8'({latch, busy, pd, rd_ready}), 8'h05);
    $display("test program done");
    // supply reset in mid-run drops busy and floats the lanes
    @(negedge clk_sys);
    rst_n = 1'b0;
    @(negedge clk_sys);
    check(8'({latch, busy, pd}), 8'h00);
    check(8'(lane_oe_n), 8'(OE_OFF));
    rst_n = 1'b1;
    $display("test reset done");
    repeat (10) @(negedge clk_sys);
    give_verdict();
  end
endmodule : tb_serial_flash_spi_front_end
`default_nettype wire
